/* adc_control_sequencer.sv */
// APB register slave and successive-approximation sequencer of the four input converter.
`include "adc_seq_regs.svh"
`default_nettype none
module adc_control_sequencer
	import adc_seq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rc_tick,
	input wire logic comp_high,
	input wire logic sleep_active,
	input wire logic [5:0] gp_pins_in,
	output logic [5:0] gp_read_data,
	output logic [7:0] dac_code,
	output logic sample_hold,
	output logic [1:0] input_select,
	output logic ref_from_pin,
	output logic core_power,
	output logic pin_config_written,
	output logic irq_request,
	output logic wake_request
);

	control_type ctrl_q;
	seq_state_type state_q;
	logic [2:0] port_config_q;
	logic [3:0] analog_mask_q;
	logic ref_pin_q;
	logic conv_done_flag_q;
	logic conv_done_enable_q;
	logic [7:0] conversion_result_q;
	logic [7:0] sar_q;
	logic [2:0] bit_idx_q;
	logic [1:0] wait_q;
	logic [4:0] presc_q;
	logic core_off_q;
	logic [7:0] rd_byte;
	logic [31:0] prdata_q;
	logic pcfg_pulse_q;
	logic [5:0] gp_read_q;
	logic setup;
	logic access;
	logic wr_en;
	logic addr_ok;
	logic sel_flags;
	logic sel_result;
	logic sel_ctrl;
	logic sel_enables;
	logic sel_pcfg;
	logic mapped;
	logic conv_tick;
	logic [4:0] tick_mask;
	logic busy;
	logic start;
	logic sleep_abort;
	logic sw_abort;
	logic abort;
	logic done_pulse;
	logic [7:0] bit_mask;
	logic [7:0] sar_kept;
	logic [7:0] final_code;
	control_type wr_ctrl;

	// Analog pin set per configuration code; bit order is input three down to zero.
	function automatic logic [3:0] analog_of(input logic [2:0] cfg);
		case (cfg)
			3'h0: analog_of = 4'hf;
			3'h1: analog_of = 4'hf;
			3'h2: analog_of = 4'h7;
			3'h3: analog_of = 4'h3;
			3'h4: analog_of = 4'h3;
			3'h5: analog_of = 4'h1;
			3'h6: analog_of = 4'h1;
			default: analog_of = 4'h0;
		endcase
	endfunction

	// The reference pin codes take input one out of the digital port as well.
	function automatic logic ref_of(input logic [2:0] cfg);
		ref_of = (cfg == 3'h1) || (cfg == 3'h3) || (cfg == 3'h5);
	endfunction

	// APB decode; the bus never stalls, so pready is held high.
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign addr_ok = (paddr[1:0] == 2'h0);
	assign sel_flags = addr_ok && (paddr[9:2] == `IDX_IRQ_FLAGS);
	assign sel_result = addr_ok && (paddr[9:2] == `IDX_RESULT);
	assign sel_ctrl = addr_ok && (paddr[9:2] == `IDX_CONTROL);
	assign sel_enables = addr_ok && (paddr[9:2] == `IDX_IRQ_ENABLES);
	assign sel_pcfg = addr_ok && (paddr[9:2] == `IDX_PIN_CONFIG);
	assign mapped = sel_flags || sel_result || sel_ctrl || sel_enables || sel_pcfg;
	assign wr_en = access && pwrite && mapped;
	assign wr_ctrl = control_type'(pwdata[7:0]);
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// Read mux; reserved and unimplemented bits read as zero.
	always_comb
	begin
		rd_byte = 8'h00;
		if (sel_flags)
			rd_byte[`DONE_FLAG_BIT] = conv_done_flag_q;
		if (sel_enables)
			rd_byte[`DONE_ENABLE_BIT] = conv_done_enable_q;
		if (sel_result)
			rd_byte = conversion_result_q;
		if (sel_ctrl)
			rd_byte = {ctrl_q.clk_sel, 1'b0, ctrl_q.in_sel, ctrl_q.go, 1'b0, ctrl_q.power_on};
		if (sel_pcfg)
			rd_byte = {5'h00, port_config_q};
	end

	// Read data is captured in the setup cycle so it is stable through the access phase.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata_q <= {24'h00_0000, rd_byte};
	end
	assign prdata = prdata_q;

	// Conversion clock: oscillator divisions come from a free running prescaler.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			presc_q <= 5'h00;
		else
			presc_q <= presc_q + 5'h01;
	end

	// The RC tick is taken as a pulse synchronous to pclk.
	always_comb
	begin
		case (ctrl_q.clk_sel)
			`CLK_SEL_DIV2: tick_mask = `TICK_MASK_DIV2;
			`CLK_SEL_DIV8: tick_mask = `TICK_MASK_DIV8;
			`CLK_SEL_DIV32: tick_mask = `TICK_MASK_DIV32;
			default: tick_mask = 5'h00;
		endcase
		if (ctrl_q.clk_sel == `CLK_SEL_RC)
			conv_tick = rc_tick;
		else
			conv_tick = ((presc_q & tick_mask) == tick_mask);
	end

	// Start, abort and completion conditions of the sequencer.
	assign busy = (state_q != ST_IDLE);
	assign start = wr_en && sel_ctrl && wr_ctrl.go && wr_ctrl.power_on && !busy;
	assign sleep_abort = sleep_active && busy && (ctrl_q.clk_sel != `CLK_SEL_RC);
	assign sw_abort = wr_en && sel_ctrl && busy && (!wr_ctrl.go || !wr_ctrl.power_on);
	assign abort = sleep_abort || sw_abort;
	assign bit_mask = 8'h01 << bit_idx_q;
	// The comparator is high when the held input is at or above the trial code times one step.
	assign sar_kept = comp_high ? sar_q : (sar_q & ~bit_mask);
	assign done_pulse = (state_q == ST_CONVERT) && conv_tick && (bit_idx_q == 3'h0) && !abort;
	assign final_code = sar_kept;

	// Sequencer state; an abort of any kind returns it to idle at once.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= ST_IDLE;
		else if (abort)
			state_q <= ST_IDLE;
		else
		begin
			case (state_q)
				ST_IDLE:
					if (start)
						state_q <= (wr_ctrl.clk_sel == `CLK_SEL_RC) ? ST_RC_WAIT : ST_SAMPLE;
				ST_RC_WAIT:
					if (wait_q == 2'h0)
						state_q <= ST_SAMPLE;
				ST_SAMPLE:
					if (conv_tick)
						state_q <= ST_CONVERT;
				ST_CONVERT:
					if (done_pulse)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// One instruction cycle of wait lets the sleep instruction retire before sampling.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wait_q <= 2'h0;
		else if (start)
			wait_q <= 2'(`INSTR_CYCLE_PCLKS - 1);
		else if (state_q == ST_RC_WAIT && wait_q != 2'h0)
			wait_q <= wait_q - 2'h1;
	end

	// Successive approximation: trial bit set, kept or dropped on each conversion tick.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sar_q <= 8'h00;
			bit_idx_q <= `RESULT_MSB_IDX;
		end
		else if (state_q == ST_SAMPLE)
		begin
			sar_q <= 8'h80;
			bit_idx_q <= `RESULT_MSB_IDX;
		end
		else if (state_q == ST_CONVERT && conv_tick && bit_idx_q != 3'h0)
		begin
			sar_q <= sar_kept | (bit_mask >> 1);
			bit_idx_q <= bit_idx_q - 3'h1;
		end
	end
	assign dac_code = sar_q;
	assign sample_hold = (state_q == ST_SAMPLE);

	// The result register has no reset so a device reset leaves the last value in place.
	always_ff @(posedge pclk)
	begin
		if (done_pulse)
			conversion_result_q <= final_code;
		else if (wr_en && sel_result)
			conversion_result_q <= pwdata[7:0];
	end

	// Control register; hardware clears the status bit at completion or sleep abort.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_q <= control_type'(`CTRL_RESET);
		else
		begin
			if (wr_en && sel_ctrl)
			begin
				ctrl_q.clk_sel <= wr_ctrl.clk_sel;
				ctrl_q.in_sel <= wr_ctrl.in_sel;
				ctrl_q.power_on <= wr_ctrl.power_on;
				ctrl_q.go <= wr_ctrl.go && wr_ctrl.power_on;
				ctrl_q.rsv5 <= 1'b0;
				ctrl_q.rsv1 <= 1'b0;
			end
			if (done_pulse || sleep_abort)
				ctrl_q.go <= 1'b0;
		end
	end
	assign input_select = ctrl_q.in_sel;

	// Core shut-off in sleep keeps the power-on bit set; leaving sleep restores power.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			core_off_q <= 1'b0;
		else if (sleep_abort)
			core_off_q <= 1'b1;
		else if (done_pulse && sleep_active && !conv_done_enable_q)
			core_off_q <= 1'b1;
		else if (!sleep_active)
			core_off_q <= 1'b0;
	end
	assign core_power = ctrl_q.power_on && !core_off_q;

	// Pin configuration; the decoded analog set and reference are kept in flops.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_config_q <= `PCFG_RESET;
			analog_mask_q <= `ANALOG_MASK_RESET;
			ref_pin_q <= 1'b0;
			pcfg_pulse_q <= 1'b0;
		end
		else
		begin
			pcfg_pulse_q <= wr_en && sel_pcfg;
			if (wr_en && sel_pcfg)
			begin
				port_config_q <= pwdata[2:0];
				analog_mask_q <= analog_of(pwdata[2:0]);
				ref_pin_q <= ref_of(pwdata[2:0]);
			end
		end
	end
	assign ref_from_pin = ref_pin_q;
	// The port-change logic outside may flag this write; software should mask those first.
	assign pin_config_written = pcfg_pulse_q;

	// Digital port read; analog pins and the reference pin read as zero.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			gp_read_q <= 6'h00;
		else
			gp_read_q <= gp_pins_in & ~{1'b0, analog_mask_q[3], 1'b0, analog_mask_q[2],
				analog_mask_q[1] | ref_pin_q, analog_mask_q[0]};
	end
	assign gp_read_data = gp_read_q;

	// Completion flag; a hardware set wins over a software clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conv_done_flag_q <= `IRQ_BIT_RESET;
			conv_done_enable_q <= `IRQ_BIT_RESET;
		end
		else
		begin
			if (done_pulse)
				conv_done_flag_q <= 1'b1;
			else if (wr_en && sel_flags)
				conv_done_flag_q <= pwdata[`DONE_FLAG_BIT];
			if (wr_en && sel_enables)
				conv_done_enable_q <= pwdata[`DONE_ENABLE_BIT];
		end
	end
	assign irq_request = conv_done_flag_q && conv_done_enable_q;
	assign wake_request = irq_request && sleep_active;

	AST_GO_CLEARED: assert property (@(posedge pclk) disable iff (!presetn)
		done_pulse |=> !ctrl_q.go && state_q == ST_IDLE)
		else $error("status bit not cleared at completion");
	AST_RESULT_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		done_pulse |=> conversion_result_q == $past(final_code))
		else $error("result not loaded at completion");
	AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
		done_pulse |=> conv_done_flag_q)
		else $error("completion flag not set");
	AST_RC_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
		start && wr_ctrl.clk_sel == `CLK_SEL_RC && !sleep_active |=>
		(state_q == ST_RC_WAIT)[*4] ##1 (state_q == ST_SAMPLE || !presetn))
		else $error("RC start delay is not one instruction cycle");
	AST_SLEEP_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_abort |=> state_q == ST_IDLE && !core_power && !ctrl_q.go)
		else $error("sleep did not abort the conversion");
	AST_SLEEP_DONE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		done_pulse && sleep_active && !conv_done_enable_q && ctrl_q.power_on |=>
		!core_power && ctrl_q.power_on)
		else $error("core not powered down after sleep completion");
	AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
		done_pulse && sleep_active && conv_done_enable_q |=> wake_request || !sleep_active)
		else $error("no wake after completion in sleep");
	AST_ANALOG_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		analog_mask_q[0] |=> !gp_read_q[0])
		else $error("analog pin read as one");
	AST_START_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
		start && !abort |=> busy && ctrl_q.go)
		else $error("start did not begin a conversion");
	AST_PCFG_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && sel_pcfg |=> pin_config_written ##1 !pin_config_written || (wr_en && sel_pcfg))
		else $error("configuration write pulse wrong");

endmodule
`default_nettype wire

/* adc_seq_regs.svh */
// Register indices, field positions, reset values and timing counts of the converter sequencer.
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// Register indices; the APB byte address is four times the index.
`define IDX_IRQ_FLAGS 8'h0c
`define IDX_RESULT 8'h1e
`define IDX_CONTROL 8'h1f
`define IDX_IRQ_ENABLES 8'h8c
`define IDX_PIN_CONFIG 8'h9f

// Field positions.
`define DONE_FLAG_BIT 6
`define DONE_ENABLE_BIT 6

// Reset values.
`define CTRL_RESET 8'h00
`define PCFG_RESET 3'h0
`define ANALOG_MASK_RESET 4'hf
`define IRQ_BIT_RESET 1'b0

// Clock select codes and conversion tick masks on the free running prescaler.
`define CLK_SEL_DIV2 2'h0
`define CLK_SEL_DIV8 2'h1
`define CLK_SEL_DIV32 2'h2
`define CLK_SEL_RC 2'h3
`define TICK_MASK_DIV2 5'h01
`define TICK_MASK_DIV8 5'h07
`define TICK_MASK_DIV32 5'h1f

// One instruction cycle is four oscillator periods; the oscillator is pclk.
`define INSTR_CYCLE_PCLKS 4
`define RESULT_MSB_IDX 3'h7

`endif

/* adc_seq_pkg.sv */
// Types shared by the converter sequencer.
`default_nettype none
package adc_seq_pkg;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_RC_WAIT = 2'b01,
		ST_SAMPLE = 2'b10,
		ST_CONVERT = 2'b11
	} seq_state_type;

	typedef struct packed
	{
		logic [1:0] clk_sel;
		logic rsv5;
		logic [1:0] in_sel;
		logic go;
		logic rsv1;
		logic power_on;
	} control_type;

endpackage
`default_nettype wire

/* adc_core_model.sv */
// Behavioural model of the analog inputs, sample-and-hold and comparator behind the sequencer.
`default_nettype none
module adc_core_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0][7:0] ain,
	input wire logic [7:0] dac_code,
	input wire logic sample_hold,
	input wire logic [1:0] input_select,
	input wire logic core_power,
	output logic rc_tick,
	output logic comp_high
);
	logic [1:0] div_q;
	logic [7:0] held_q;
	logic junk_q;

	// The RC tick runs at a third of pclk so it never lines up with the prescaler.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_q <= 2'h0;
		else
			div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
	end

	// The hold capacitor follows the routed input only while sampling is requested.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			held_q <= 8'h00;
			junk_q <= 1'b0;
		end
		else
		begin
			junk_q <= ~junk_q;
			if (sample_hold)
				held_q <= ain[input_select];
		end
	end

	assign rc_tick = (div_q == 2'h2);
	// A powered-down comparator gives a toggling level, so a result built without power is wrong.
	assign comp_high = core_power ? (held_q >= dac_code) : junk_q;
endmodule
`default_nettype wire

/* adc_control_sequencer_tb.sv */
// Self-checking testbench of the converter sequencer.
`include "adc_seq_regs.svh"
`default_nettype none
module adc_control_sequencer_tb import adc_seq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, rc_tick, comp_high, sample_hold, ref_from_pin, core_power;
	logic pin_config_written, irq_request, wake_request;
	logic sleep_active = 1'b0;
	logic [5:0] gp_pins_in = 6'h3f;
	logic [5:0] gp_read_data;
	logic [7:0] dac_code;
	logic [1:0] input_select;
	logic [3:0][7:0] ain = {8'h00, 8'hff, 8'h80, 8'h01};
	logic [31:0] rd;
	logic er;
	int bad_count = 0;
	int check_count = 0;
	localparam logic [9:0] a_flg = {`IDX_IRQ_FLAGS, 2'b00};
	localparam logic [9:0] a_res = {`IDX_RESULT, 2'b00};
	localparam logic [9:0] a_ctl = {`IDX_CONTROL, 2'b00};
	localparam logic [9:0] a_en = {`IDX_IRQ_ENABLES, 2'b00};
	localparam logic [9:0] a_pcf = {`IDX_PIN_CONFIG, 2'b00};

	adc_control_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rc_tick(rc_tick), .comp_high(comp_high), .sleep_active(sleep_active),
		.gp_pins_in(gp_pins_in), .gp_read_data(gp_read_data), .dac_code(dac_code),
		.sample_hold(sample_hold), .input_select(input_select), .ref_from_pin(ref_from_pin),
		.core_power(core_power), .pin_config_written(pin_config_written),
		.irq_request(irq_request), .wake_request(wake_request));

	adc_core_model core (.pclk(pclk), .presetn(presetn), .ain(ain), .dac_code(dac_code),
		.sample_hold(sample_hold), .input_select(input_select), .core_power(core_power),
		.rc_tick(rc_tick), .comp_high(comp_high));

	// Clock of 100 ns period.
	initial
	begin
		forever #50 pclk = ~pclk;
	end

	task automatic tally_and_finish();
		if (bad_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; read data and error are taken at the edge where pready is seen high.
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			bad_count++;
			tally_and_finish();
		end
	endtask

	// Polls the status bit; the bound covers the slowest clock choice with margin.
	task automatic wait_idle();
		int n;
		n = 0;
		do
		begin
			apb(1'b0, a_ctl, 32'h0);
			n++;
		end
		while (rd[2] !== 1'b0 && n < 300);
		if (n >= 300)
		begin
			bad_count++;
			tally_and_finish();
		end
	endtask

	// The port read is registered, so the reset-time zero is left behind before the pins are judged.
	task automatic pins_and_regs();
		repeat (2) @(negedge pclk);
		chk("gp analog", {26'h0, gp_read_data}, 32'h28);
		apb(1'b1, a_ctl, 32'h22);
		apb(1'b0, a_ctl, 32'h0);
		chk("ctrl reserved", rd, 32'h0);
		apb(1'b0, a_pcf, 32'h0);
		chk("pcfg reset", rd, 32'h0);
		apb(1'b1, a_pcf, 32'h1);
		@(negedge pclk);
		chk("cfg pulse", {31'h0, pin_config_written}, 32'h1);
		chk("ref pin", {31'h0, ref_from_pin}, 32'h1);
		apb(1'b1, a_pcf, 32'h7);
		repeat (2) @(negedge pclk);
		chk("gp digital", {26'h0, gp_read_data}, 32'h3f);
		chk("ref supply", {31'h0, ref_from_pin}, 32'h0);
		apb(1'b1, a_pcf, 32'h0);
		apb(1'b0, 10'h004, 32'h0);
		chk("unmapped err", {31'h0, er}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, a_ctl, 32'h04);
		apb(1'b0, a_ctl, 32'h0);
		chk("go unpowered", rd, 32'h0);
		chk("power off", {31'h0, core_power}, 32'h0);
		apb(1'b1, a_ctl, 32'h85);
		apb(1'b1, a_ctl, 32'h01);
		apb(1'b0, a_ctl, 32'h0);
		chk("sw abort", rd, 32'h01);
	endtask

	// Each clock choice with its own input; the last pass uses the RC clock.
	task automatic conv_all();
		logic [7:0] c;
		for (int i = 0; i < 4; i++)
		begin
			c = {i[1:0], 1'b0, i[1:0], 3'b101};
			apb(1'b1, a_ctl, {24'h0, c});
			apb(1'b0, a_ctl, 32'h0);
			chk("busy", {31'h0, rd[2]}, 32'h1);
			chk("route", {30'h0, input_select}, {30'h0, i[1:0]});
			if (i == 3)
				chk("rc delay", {31'h0, sample_hold}, 32'h0);
			wait_idle();
			apb(1'b0, a_res, 32'h0);
			chk("result", rd, {24'h0, ain[i]});
			apb(1'b0, a_flg, 32'h0);
			chk("done flag", {31'h0, rd[6]}, 32'h1);
			apb(1'b1, a_flg, 32'h0);
		end
	endtask

	// RC conversion started just before sleep, with the interrupt enabled or masked.
	task automatic sleep_conv(input logic en);
		apb(1'b1, a_en, {25'h0, en, 6'h0});
		apb(1'b1, a_ctl, 32'hc5);
		sleep_active <= 1'b1;
		wait_idle();
		@(negedge pclk);
		chk("wake", {31'h0, wake_request}, {31'h0, en});
		chk("irq gate", {31'h0, irq_request}, {31'h0, en});
		chk("sleep power", {31'h0, core_power}, {31'h0, en});
		chk("power bit", {31'h0, rd[0]}, 32'h1);
		@(posedge pclk);
		sleep_active <= 1'b0;
		apb(1'b1, a_flg, 32'h0);
		apb(1'b1, a_en, 32'h0);
	endtask

	task automatic sleep_abort_and_reset();
		apb(1'b1, a_ctl, 32'h85);
		sleep_active <= 1'b1;
		repeat (3) @(negedge pclk);
		apb(1'b0, a_ctl, 32'h0);
		chk("abort go", {31'h0, rd[2]}, 32'h0);
		chk("abort power bit", {31'h0, rd[0]}, 32'h1);
		chk("abort power", {31'h0, core_power}, 32'h0);
		sleep_active <= 1'b0;
		apb(1'b1, a_ctl, 32'h8d);
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		chk("reset power", {31'h0, core_power}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, a_ctl, 32'h0);
		chk("reset ctrl", rd, 32'h0);
		apb(1'b0, a_res, 32'h0);
		chk("result kept", rd, 32'h01);
	endtask

	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		pins_and_regs();
		conv_all();
		sleep_conv(1'b1);
		sleep_conv(1'b0);
		sleep_abort_and_reset();
		tally_and_finish();
	end
endmodule
`default_nettype wire
